// ===== hdl/fic_defs.svh
`ifndef FIC_DEFS_SVH
`define FIC_DEFS_SVH

// Register addresses
`define FIC_ADDR_ENABLE       8'ha8
`define FIC_ADDR_PRIO_LOW     8'hb8
`define FIC_ADDR_PRIO_HIGH    8'hb7
`define FIC_ADDR_ENABLE_BITOP 8'hc0
`define FIC_ADDR_PRIO_BITOP   8'hc1
`define FIC_ADDR_EVT_STATUS   8'hc2
`define FIC_ADDR_EVT_MASK     8'hc3
`define FIC_ADDR_ACTIVE       8'hc4
`define FIC_ADDR_PENDING      8'hc5

// Field positions
`define FIC_GLOBAL_BIT        7
`define FIC_RESERVED_BIT      7
`define FIC_BITOP_VALUE_BIT   3
`define FIC_BITOP_INDEX_MSB   2
`define FIC_EVT_ACCEPT_BIT    0
`define FIC_EVT_NEST_BIT      1
`define FIC_EVT_RETURN_BIT    2

// Source positions, also the same-level polling order
`define FIC_SRC_EXT0          3'h0
`define FIC_SRC_TIMER0        3'h1
`define FIC_SRC_EXT1          3'h2
`define FIC_SRC_TIMER1        3'h3
`define FIC_SRC_SERIAL        3'h4
`define FIC_SRC_TIMER2        3'h5
`define FIC_SRC_COUNTER_ARRAY 3'h6
`define FIC_NUM_SRC           7

// Vector addresses
`define FIC_VEC_EXT0          16'h0003
`define FIC_VEC_TIMER0        16'h000b
`define FIC_VEC_EXT1          16'h0013
`define FIC_VEC_TIMER1        16'h001b
`define FIC_VEC_SERIAL        16'h0023
`define FIC_VEC_TIMER2        16'h002b
`define FIC_VEC_COUNTER_ARRAY 16'h0033

// Reset values and level constants
`define FIC_RESET_BYTE        8'h00
`define FIC_RESET_SRC         7'h00
`define FIC_RESET_EVT         3'h0
`define FIC_RESET_ACTIVE      4'h0
`define FIC_LEVEL_LOWEST      2'h0
`define FIC_LEVEL_HIGHEST     2'h3

`endif

// ===== hdl/fic_pkg.sv
package fic_pkg;
    typedef logic [1:0]  fic_level_type;
    typedef logic [15:0] fic_vector_type;
    typedef logic [6:0]  fic_src_type;
    typedef logic [2:0]  fic_index_type;
    typedef logic [2:0]  fic_event_type;
    typedef logic [3:0]  fic_active_type;
endpackage : fic_pkg

// ===== hdl/fic_source_cell.sv
`timescale 1ns/1ns
module fic_source_cell (
    // Source and its configuration
    input  wire logic                  flag,
    input  wire logic                  sourceGate,
    input  wire logic                  globalGate,
    input  wire logic                  prioHigh,
    input  wire logic                  prioLow,
    // Gated request and its level
    output      logic                  request,
    output      fic_pkg::fic_level_type level
);
    assign request = flag && sourceGate && globalGate; // RL5 RL6
    assign level   = {prioHigh, prioLow};             // RL9
endmodule : fic_source_cell

// ===== hdl/fic_controller.sv
// Operation
// [RL1] Seven request sources, each with its own vector address.
// [RL2] Serial source is receive OR transmit; timer 2 is overflow OR external.
// [RL3] Counter-array request vectors to 0033H.
// [RL4] Other vectors at 0003H, 000BH, 0013H, 001BH, 0023H, 002BH.
// [RL5] A source requests only while its own enable bit is one.
// [RL6] Global enable at bit 7 masks every source when zero.
// [RL7] Enable bits: 7 global, 6 counter-array, 5..0 timer2 down to ext0.
// [RL8] Enable register resets to zero and supports single-bit set and clear.
// [RL9] Level is high priority bit over low priority bit, 0 lowest, 3 highest.
// [RL10] A running routine is pre-empted only by a strictly higher level.
// [RL11] A level 3 routine holds off every other request until done.
// [RL12] Simultaneous requests of different levels: the highest level wins.
// [RL13] Equal-level requests are resolved by a fixed polling order.
// [RL14] Polling order: ext0, timer0, ext1, timer1, serial, timer2, counter-array.
// [RL15] Low priority register: same bit layout, bit 7 reserved, resets zero.
// [RL16] High priority register: same layout, bit 7 reserved, resets zero.
`timescale 1ns/1ns
`include "fic_defs.svh"
module fic_controller (
    // Clock, reset, enable
    input  wire logic                   ref_clk,
    input  wire logic                   reset_n,
    input  wire logic                   clkEn,
    // Register port
    input  wire logic [7:0]             regAddr,
    input  wire logic [7:0]             regWData,
    input  wire logic                   regWrite,
    input  wire logic                   regRead,
    output      logic [7:0]             regRData,
    // External request pins, active low
    input  wire logic                   extRequest0_n,
    input  wire logic                   extRequest1_n,
    // On-chip request flags
    input  wire logic                   timer0OverflowFlag,
    input  wire logic                   timer1OverflowFlag,
    input  wire logic                   timer2OverflowFlag,
    input  wire logic                   timer2ExternalFlag,
    input  wire logic                   serialReceiveFlag,
    input  wire logic                   serialTransmitFlag,
    input  wire logic                   counterArrayFlag,
    // CPU core handshake
    input  wire logic                   cpuAck,
    input  wire logic                   cpuReturn,
    output      logic                   irqRequest,
    output      fic_pkg::fic_vector_type vectorAddr,
    output      fic_pkg::fic_level_type  irqLevel,
    // Event interrupt
    output      logic                   eventIrq
);
    logic [1:0]               ext0Sync;
    logic [1:0]               ext1Sync;
    logic [7:0]               sourceEnable;
    fic_pkg::fic_src_type     prioLowBits;
    fic_pkg::fic_src_type     prioHighBits;
    fic_pkg::fic_event_type   eventStatus;
    fic_pkg::fic_event_type   eventMask;
    fic_pkg::fic_active_type  inProgress;
    fic_pkg::fic_index_type   selIdx;
    fic_pkg::fic_src_type     sourceFlags;
    fic_pkg::fic_src_type     gatedReq;
    fic_pkg::fic_level_type   srcLevel [`FIC_NUM_SRC];
    logic                     bestFound;
    fic_pkg::fic_index_type   bestIdx;
    fic_pkg::fic_level_type   bestLvl;
    logic                     anyActive;
    fic_pkg::fic_level_type   curLevel;
    logic                     allowed;
    logic                     accept;
    logic                     retire;
    fic_pkg::fic_event_type   eventSet;
    fic_pkg::fic_index_type   bitIndex;

    // Pins pass two flops before use
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ext0Sync <= 2'h3;
            ext1Sync <= 2'h3;
        end else if (clkEn) begin
            ext0Sync <= {ext0Sync[0], extRequest0_n};
            ext1Sync <= {ext1Sync[0], extRequest1_n};
        end
    end

    // Seven sources, bit position equals polling rank
    always_comb begin
        sourceFlags                           = `FIC_RESET_SRC;                          // RL1
        sourceFlags[`FIC_SRC_EXT0]            = !ext0Sync[1];
        sourceFlags[`FIC_SRC_TIMER0]          = timer0OverflowFlag;
        sourceFlags[`FIC_SRC_EXT1]            = !ext1Sync[1];
        sourceFlags[`FIC_SRC_TIMER1]          = timer1OverflowFlag;
        sourceFlags[`FIC_SRC_SERIAL]          = serialReceiveFlag || serialTransmitFlag; // RL2
        sourceFlags[`FIC_SRC_TIMER2]          = timer2OverflowFlag || timer2ExternalFlag; // RL2
        sourceFlags[`FIC_SRC_COUNTER_ARRAY]   = counterArrayFlag;
    end

    genvar gi;
    generate
        for (gi = 0; gi < `FIC_NUM_SRC; gi++) begin : g_src
            fic_source_cell u_cell (
                .flag       (sourceFlags[gi]),
                .sourceGate (sourceEnable[gi]),                 // RL7
                .globalGate (sourceEnable[`FIC_GLOBAL_BIT]),    // RL6
                .prioHigh   (prioHighBits[gi]),
                .prioLow    (prioLowBits[gi]),
                .request    (gatedReq[gi]),
                .level      (srcLevel[gi])
            );
        end
    endgenerate

    // Higher level wins; on a tie the lower bit position wins
    always_comb begin
        bestFound = 1'b0;
        bestIdx   = `FIC_SRC_EXT0;
        bestLvl   = `FIC_LEVEL_LOWEST;
        for (int i = `FIC_NUM_SRC - 1; i >= 0; i--) begin
            if (gatedReq[i] && (!bestFound || srcLevel[i] >= bestLvl)) begin // RL12 RL13 RL14
                bestFound = 1'b1;
                bestIdx   = fic_pkg::fic_index_type'(i);
                bestLvl   = srcLevel[i];
            end
        end
    end

    // Highest level whose routine is in progress
    always_comb begin
        anyActive = 1'b0;
        curLevel  = `FIC_LEVEL_LOWEST;
        for (int l = 0; l < 4; l++) begin
            if (inProgress[l]) begin
                anyActive = 1'b1;
                curLevel  = fic_pkg::fic_level_type'(l);
            end
        end
    end

    // Level 3 in progress can never be exceeded, so it blocks all
    assign allowed  = bestFound && (!anyActive || bestLvl > curLevel); // RL10 RL11
    assign accept   = clkEn && cpuAck && irqRequest;
    assign retire   = clkEn && cpuReturn && anyActive;
    assign bitIndex = regWData[`FIC_BITOP_INDEX_MSB:0];

    function automatic fic_pkg::fic_vector_type vectorOf(input fic_pkg::fic_index_type idx);
        unique case (idx)
            `FIC_SRC_EXT0:          vectorOf = `FIC_VEC_EXT0;          // RL4
            `FIC_SRC_TIMER0:        vectorOf = `FIC_VEC_TIMER0;
            `FIC_SRC_EXT1:          vectorOf = `FIC_VEC_EXT1;
            `FIC_SRC_TIMER1:        vectorOf = `FIC_VEC_TIMER1;
            `FIC_SRC_SERIAL:        vectorOf = `FIC_VEC_SERIAL;
            `FIC_SRC_TIMER2:        vectorOf = `FIC_VEC_TIMER2;
            `FIC_SRC_COUNTER_ARRAY: vectorOf = `FIC_VEC_COUNTER_ARRAY; // RL3
            default:                vectorOf = `FIC_VEC_EXT0;
        endcase
    endfunction : vectorOf

    // Request is dropped for a cycle after any ack or return so the
    // core never sees a choice made against a stale in-progress set
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            irqRequest <= 1'b0;
            vectorAddr <= `FIC_VEC_EXT0;
            irqLevel   <= `FIC_LEVEL_LOWEST;
            selIdx     <= `FIC_SRC_EXT0;
        end else if (clkEn) begin
            irqRequest <= allowed && !cpuAck && !cpuReturn; // RL10 RL11
            vectorAddr <= vectorOf(bestIdx);                 // RL1
            irqLevel   <= bestLvl;                           // RL12
            selIdx     <= bestIdx;
        end
    end

    // One bit per level; a return with no same-cycle ack retires the highest running level
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            inProgress <= `FIC_RESET_ACTIVE;
        end else if (clkEn) begin
            if (accept) begin
                inProgress[irqLevel] <= 1'b1; // RL10
            end else if (retire) begin
                inProgress[curLevel] <= 1'b0;
            end
        end
    end

    // Enable register: byte write or single-bit set/clear
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sourceEnable <= `FIC_RESET_BYTE; // RL8
        end else if (clkEn && regWrite) begin
            if (regAddr == `FIC_ADDR_ENABLE) begin
                sourceEnable <= regWData; // RL7
            end else if (regAddr == `FIC_ADDR_ENABLE_BITOP) begin
                sourceEnable[bitIndex] <= regWData[`FIC_BITOP_VALUE_BIT]; // RL8
            end
        end
    end

    // Priority registers; bit 7 is not stored and reads as zero
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prioLowBits  <= `FIC_RESET_SRC; // RL15
            prioHighBits <= `FIC_RESET_SRC; // RL16
        end else if (clkEn && regWrite) begin
            if (regAddr == `FIC_ADDR_PRIO_LOW) begin
                prioLowBits <= regWData[`FIC_RESERVED_BIT-1:0]; // RL15
            end else if (regAddr == `FIC_ADDR_PRIO_HIGH) begin
                prioHighBits <= regWData[`FIC_RESERVED_BIT-1:0]; // RL16
            end else if (regAddr == `FIC_ADDR_PRIO_BITOP && bitIndex != `FIC_RESERVED_BIT) begin
                prioLowBits[bitIndex] <= regWData[`FIC_BITOP_VALUE_BIT];
            end
        end
    end

    // Event status: hardware set beats a same-cycle write-one-to-clear
    always_comb begin
        eventSet                        = `FIC_RESET_EVT;
        eventSet[`FIC_EVT_ACCEPT_BIT]   = accept;
        eventSet[`FIC_EVT_NEST_BIT]     = accept && anyActive;
        eventSet[`FIC_EVT_RETURN_BIT]   = retire;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            eventStatus <= `FIC_RESET_EVT;
        end else if (clkEn) begin
            if (regWrite && regAddr == `FIC_ADDR_EVT_STATUS) begin
                eventStatus <= (eventStatus & ~regWData[2:0]) | eventSet;
            end else begin
                eventStatus <= eventStatus | eventSet;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            eventMask <= `FIC_RESET_EVT;
        end else if (clkEn && regWrite && regAddr == `FIC_ADDR_EVT_MASK) begin
            eventMask <= regWData[2:0];
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            eventIrq <= 1'b0;
        end else if (clkEn) begin
            eventIrq <= |(eventStatus & eventMask);
        end
    end

    // Read data stand only in the cycle after the read strobe
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            regRData <= `FIC_RESET_BYTE;
        end else if (clkEn) begin
            regRData <= `FIC_RESET_BYTE;
            if (regRead) begin
                unique case (regAddr)
                    `FIC_ADDR_ENABLE:     regRData <= sourceEnable;
                    `FIC_ADDR_PRIO_LOW:   regRData <= {1'b0, prioLowBits};
                    `FIC_ADDR_PRIO_HIGH:  regRData <= {1'b0, prioHighBits};
                    `FIC_ADDR_EVT_STATUS: regRData <= {5'h00, eventStatus};
                    `FIC_ADDR_EVT_MASK:   regRData <= {5'h00, eventMask};
                    `FIC_ADDR_ACTIVE:     regRData <= {4'h0, inProgress};
                    `FIC_ADDR_PENDING:    regRData <= {1'b0, gatedReq};
                    default:              regRData <= `FIC_RESET_BYTE;
                endcase
            end
        end
    end

    // Checking helpers: independent max level and tie set
    fic_pkg::fic_level_type topReqLevel;
    fic_pkg::fic_src_type   sameTopReq;
    always_comb begin
        topReqLevel = `FIC_LEVEL_LOWEST;
        sameTopReq  = `FIC_RESET_SRC;
        for (int i = 0; i < `FIC_NUM_SRC; i++) begin
            if (gatedReq[i] && srcLevel[i] > topReqLevel) begin
                topReqLevel = srcLevel[i];
            end
        end
        for (int i = 0; i < `FIC_NUM_SRC; i++) begin
            sameTopReq[i] = gatedReq[i] && srcLevel[i] == topReqLevel;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_global_gate: assert property ((clkEn && !sourceEnable[`FIC_GLOBAL_BIT]) |=> !irqRequest) // RL6
        else $error("request raised while global enable is clear");
    a_source_gate: assert property ($rose(irqRequest) |-> $past(sourceEnable[bestIdx])) // RL5
        else $error("request raised for a disabled source");
    a_counter_vector: assert property ((irqRequest && selIdx == `FIC_SRC_COUNTER_ARRAY) // RL3
        |-> vectorAddr == `FIC_VEC_COUNTER_ARRAY)
        else $error("counter-array vector wrong");
    a_strict_nesting: assert property ((irqRequest && anyActive) |-> irqLevel > curLevel) // RL10
        else $error("request not above running level");
    a_top_level_hold: assert property ((clkEn && inProgress[3]) |=> !irqRequest) // RL11
        else $error("request raised under a level 3 routine");
    a_level_select: assert property (($rose(irqRequest) && $past(clkEn)) |-> irqLevel == $past(topReqLevel)) // RL12
        else $error("highest pending level not chosen");
    a_poll_order: assert property (($rose(irqRequest) && $past(clkEn)) // RL13 RL14
        |-> ($past(sameTopReq) & ((7'h01 << selIdx) - 7'h01)) == `FIC_RESET_SRC)
        else $error("polling order violated");
    a_enable_reset: assert property (disable iff (1'b0) $rose(reset_n) |-> sourceEnable == `FIC_RESET_BYTE) // RL8
        else $error("enable register not zero after reset");
    a_ack_records: assert property (accept |=> inProgress[$past(irqLevel)] && eventStatus[`FIC_EVT_ACCEPT_BIT]) // RL10
        else $error("accepted level not recorded");
    a_prio_reserved: assert property ((clkEn && regRead && regAddr == `FIC_ADDR_PRIO_HIGH) // RL16
        |=> regRData[`FIC_RESERVED_BIT] == 1'b0 && regRData[6:0] == $past(prioHighBits))
        else $error("high priority readback wrong");

    // Bit-level register writes
    a_enable_bitop: assert property ( // RL8
        (clkEn && regWrite && regAddr == `FIC_ADDR_ENABLE_BITOP)
        |=> sourceEnable[$past(bitIndex)] == $past(regWData[`FIC_BITOP_VALUE_BIT]))
        else $error("enable bit-op lost");
    a_prio_bitop: assert property ( // RL15
        (clkEn && regWrite && regAddr == `FIC_ADDR_PRIO_BITOP && bitIndex != `FIC_RESERVED_BIT)
        |=> prioLowBits[$past(bitIndex)] == $past(regWData[`FIC_BITOP_VALUE_BIT]))
        else $error("priority bit-op lost");
    a_high_no_bitop: assert property ( // RL16
        (clkEn && regWrite && regAddr == `FIC_ADDR_PRIO_BITOP) |=> $stable(prioHighBits))
        else $error("high priority changed by bit-op");
    // Idle read data is zero so several slaves can share an OR'ed read bus
    a_read_idle: assert property ((clkEn && !regRead) |=> regRData == `FIC_RESET_BYTE)
        else $error("read data outside the answer cycle");

    // Handshake and gating
    a_ack_drops: assert property ((accept || retire) |=> !irqRequest) // RL10
        else $error("request held through ack or return");
    a_return_clears: assert property ((retire && !accept) |=> !inProgress[$past(curLevel)]) // RL10 RL11
        else $error("returned level still running");
    a_nest_event: assert property ((accept && anyActive) |=> eventStatus[`FIC_EVT_NEST_BIT]) // RL10
        else $error("nesting not recorded");
    a_pending_gate: assert property (!sourceEnable[`FIC_GLOBAL_BIT] |-> gatedReq == `FIC_RESET_SRC) // RL6
        else $error("pending set while globally masked");

    c_nested: cover property (accept && anyActive);
    c_top_level: cover property (accept && irqLevel == `FIC_LEVEL_HIGHEST);
    c_tie: cover property ($countones(sameTopReq) > 1 && bestFound);
    c_counter_serviced: cover property (accept && selIdx == `FIC_SRC_COUNTER_ARRAY);
    c_return: cover property (retire);
endmodule : fic_controller

// ===== verification/fic_cpu_model.sv
`timescale 1ns/1ns
module fic_cpu_model (
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    reset_n,
    // Controller side
    input  wire logic                    irqRequest,
    input  wire fic_pkg::fic_vector_type vectorAddr,
    input  wire fic_pkg::fic_level_type  irqLevel,
    output      logic                    cpuAck,
    output      logic                    cpuReturn,
    // Bench control and what the core took
    input  wire logic                    autoAck,
    input  wire logic [3:0]              ackDelay,
    input  wire logic                    retGo,
    output      fic_pkg::fic_vector_type takenVector,
    output      fic_pkg::fic_level_type  takenLevel
);
    logic [3:0] waitCount;

    // A slow core lets the request stand ackDelay cycles; never acks beside a return
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cpuAck    <= 1'b0;
            waitCount <= 4'h0;
        end else begin
            cpuAck    <= 1'b0;
            waitCount <= 4'h0;
            if (autoAck && irqRequest && !cpuAck && !retGo) begin
                if (waitCount == ackDelay)
                    cpuAck <= 1'b1;
                else
                    waitCount <= waitCount + 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cpuReturn   <= 1'b0;
            takenVector <= 16'h0000;
            takenLevel  <= 2'h0;
        end else begin
            cpuReturn <= retGo;
            if (cpuAck && irqRequest) begin
                takenVector <= vectorAddr;
                takenLevel  <= irqLevel;
            end
        end
    end
endmodule : fic_cpu_model

// ===== verification/fic_controller_tb_top.sv
`timescale 1ns/1ns
module fic_controller_tb_top;
    localparam logic [15:0] VEC [0:6] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b, 16'h0033};
    localparam int          SRC [0:8] = '{0, 1, 2, 3, 4, 4, 5, 5, 6};

    logic                    ref_clk = 1'b0;
    logic                    reset_n = 1'b0;
    logic [7:0]              regAddr = 8'h00;
    logic [7:0]              regWData = 8'h00;
    logic                    regWrite = 1'b0;
    logic                    regRead = 1'b0;
    logic [7:0]              regRData;
    logic [8:0]              raw = 9'h000;
    logic                    cpuAck;
    logic                    cpuReturn;
    logic                    irqRequest;
    fic_pkg::fic_vector_type vectorAddr;
    fic_pkg::fic_level_type  irqLevel;
    logic                    eventIrq;
    logic                    autoAck = 1'b0;
    logic [3:0]              ackDelay = 4'h0;
    logic                    retGo = 1'b0;
    fic_pkg::fic_vector_type takenVector;
    fic_pkg::fic_level_type  takenLevel;
    logic [1:0]              lv;
    int                      mismatches = 0;
    int                      compares = 0;

    always #2 ref_clk = ~ref_clk;

    // Raw bits: ext0, t0, ext1, t1, rx, tx, t2 overflow, t2 external, counter array
    fic_controller uut (
        .ref_clk(ref_clk), .reset_n(reset_n), .clkEn(1'b1),
        .regAddr(regAddr), .regWData(regWData), .regWrite(regWrite), .regRead(regRead), .regRData(regRData),
        .extRequest0_n(~raw[0]), .extRequest1_n(~raw[2]),
        .timer0OverflowFlag(raw[1]), .timer1OverflowFlag(raw[3]), .timer2OverflowFlag(raw[6]),
        .timer2ExternalFlag(raw[7]), .serialReceiveFlag(raw[4]), .serialTransmitFlag(raw[5]),
        .counterArrayFlag(raw[8]), .cpuAck(cpuAck), .cpuReturn(cpuReturn), .irqRequest(irqRequest),
        .vectorAddr(vectorAddr), .irqLevel(irqLevel), .eventIrq(eventIrq)
    );

    fic_cpu_model cpu (
        .ref_clk(ref_clk), .reset_n(reset_n), .irqRequest(irqRequest), .vectorAddr(vectorAddr),
        .irqLevel(irqLevel), .cpuAck(cpuAck), .cpuReturn(cpuReturn), .autoAck(autoAck),
        .ackDelay(ackDelay), .retGo(retGo), .takenVector(takenVector), .takenLevel(takenLevel)
    );

    task automatic end_of_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk_reg

    task automatic chk_out(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk_out

    // Strobes drop for one edge between accesses so no signal is driven twice in a step
    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        regAddr  <= addr;
        regWData <= data;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        @(posedge ref_clk);
    endtask : reg_write

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp, input string what);
        regAddr <= addr;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        @(posedge ref_clk);
        chk_reg(what, exp, regRData);
    endtask : rd_chk

    // Six edges cover the two-stage pin synchroniser plus the registered request
    task automatic expect_irq(input logic flag, input logic [15:0] vec, input logic [1:0] lvl);
        repeat (6) @(posedge ref_clk);
        chk_out("irqRequest", {15'h0, flag}, {15'h0, irqRequest});
        if (flag) begin
            chk_out("vectorAddr", vec, vectorAddr);
            chk_out("irqLevel", {14'h0, lvl}, {14'h0, irqLevel});
        end
    endtask : expect_irq

    task automatic wait_ack(input logic [15:0] vec, input logic [1:0] lvl);
        int n = 0;
        while (cpuAck !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        @(posedge ref_clk);
        chk_out("takenVector", vec, takenVector);
        chk_out("takenLevel", {14'h0, lvl}, {14'h0, takenLevel});
    endtask : wait_ack

    task automatic ret_pulse;
        retGo <= 1'b1;
        @(posedge ref_clk);
        retGo <= 1'b0;
        @(posedge ref_clk);
    endtask : ret_pulse

    initial begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        rd_chk(8'ha8, 8'h00, "enable");
        rd_chk(8'hb8, 8'h00, "prioLow");
        rd_chk(8'hb7, 8'h00, "prioHigh");
        reg_write(8'hb8, 8'hff);
        rd_chk(8'hb8, 8'h7f, "prioLow");
        reg_write(8'hb7, 8'hff);
        rd_chk(8'hb7, 8'h7f, "prioHigh");
        reg_write(8'h10, 8'hff);
        rd_chk(8'h10, 8'h00, "unmapped");
        reg_write(8'hc0, 8'h0f);
        rd_chk(8'ha8, 8'h80, "enable");
        reg_write(8'ha8, 8'h7f);
        reg_write(8'hc0, 8'h06);
        rd_chk(8'ha8, 8'h3f, "enable");
        reg_write(8'hc1, 8'h06);
        reg_write(8'hc1, 8'h0f);
        rd_chk(8'hb8, 8'h3f, "prioLow");
        $display("test registers done");
        raw <= 9'h002;
        expect_irq(1'b0, 16'h0, 2'h0);
        reg_write(8'ha8, 8'h7f);
        expect_irq(1'b0, 16'h0, 2'h0);
        reg_write(8'ha8, 8'hfd);
        expect_irq(1'b0, 16'h0, 2'h0);
        reg_write(8'ha8, 8'h82);
        expect_irq(1'b1, 16'h000b, 2'h3);
        raw <= 9'h000;
        $display("test gating done");
        for (int k = 0; k < 9; k++) begin
            lv = 2'(k % 4);
            reg_write(8'hb8, {7'h0, lv[0]} << SRC[k]);
            reg_write(8'hb7, {7'h0, lv[1]} << SRC[k]);
            reg_write(8'ha8, 8'h80 | (8'h01 << SRC[k]));
            raw <= 9'h001 << k;
            expect_irq(1'b1, VEC[SRC[k]], lv);
            raw <= 9'h000;
            expect_irq(1'b0, 16'h0, 2'h0);
        end
        $display("test vectors done");
        reg_write(8'hb8, 8'h00);
        reg_write(8'hb7, 8'h40);
        reg_write(8'ha8, 8'hff);
        raw <= 9'h15f;
        expect_irq(1'b1, 16'h0033, 2'h2);
        rd_chk(8'hc5, 8'h7f, "pending");
        reg_write(8'hb7, 8'h00);
        for (int i = 0; i < 7; i++) begin
            expect_irq(1'b1, VEC[i], 2'h0);
            reg_write(8'hc0, 8'(i));
        end
        expect_irq(1'b0, 16'h0, 2'h0);
        raw <= 9'h000;
        $display("test polling done");
        reg_write(8'hb8, 8'h4b);
        reg_write(8'hb7, 8'h45);
        reg_write(8'ha8, 8'hff);
        autoAck  <= 1'b1;
        ackDelay <= 4'h3;
        raw      <= 9'h002;
        wait_ack(16'h000b, 2'h1);
        raw <= 9'h00a;
        expect_irq(1'b0, 16'h0, 2'h0);
        ackDelay <= 4'h0;
        raw      <= 9'h00e;
        wait_ack(16'h0013, 2'h2);
        raw <= 9'h10e;
        wait_ack(16'h0033, 2'h3);
        autoAck <= 1'b0;
        raw     <= 9'h10f;
        expect_irq(1'b0, 16'h0, 2'h0);
        rd_chk(8'hc4, 8'h0e, "active");
        ret_pulse;
        expect_irq(1'b1, 16'h0003, 2'h3);
        $display("test nesting done");
        rd_chk(8'hc2, 8'h07, "eventStatus");
        chk_out("eventIrq", 16'h0, {15'h0, eventIrq});
        reg_write(8'hc3, 8'h04);
        @(posedge ref_clk);
        chk_out("eventIrq", 16'h1, {15'h0, eventIrq});
        reg_write(8'hc2, 8'h04);
        @(posedge ref_clk);
        chk_out("eventIrq", 16'h0, {15'h0, eventIrq});
        rd_chk(8'hc2, 8'h03, "eventStatus");
        raw <= 9'h000;
        $display("test events done");
        end_of_test;
    end

    initial begin
        #100000;
        mismatches++;
        end_of_test;
    end
endmodule : fic_controller_tb_top
